// file: hwph_pkg.sv
// Constants, register map and carrier types of the wake handshake block.
package hwph_pkg;
   localparam int CLK_MHZ = 125;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PADFN    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h18;

   localparam int CTRL_W  = 6;
   localparam int PADFN_W = 4;
   localparam int IVAL_W  = 16;
   localparam int IRQ_W   = 4;
   localparam int STAT_W  = 5;

   localparam logic [CTRL_W-1:0]  CTRL_RST  = 6'h06;
   localparam logic [PADFN_W-1:0] PADFN_RST = 4'h0;
   localparam logic [PADFN_W-1:0] PADFN_HS  = 4'h0;
   localparam logic [IVAL_W-1:0]  IVAL_RST  = 16'h0000;
   localparam logic [IRQ_W-1:0]   IRQ_RST   = 4'h0;

   localparam int IRQ_HOST_WAKE  = 0;
   localparam int IRQ_TIMER_WAKE = 1;
   localparam int IRQ_SLEEP      = 2;
   localparam int IRQ_POWER_UP   = 3;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_SLEEP = 2'b01,
      ST_SHUT  = 2'b11,
      ST_PWRUP = 2'b10
   } hwph_state_type;

   typedef struct packed {
      logic shutdown;
      logic svcReq;
      logic sleepOk;
      logic hostPol;
      logic devPol;
      logic hsEn;
   } hwph_ctrl_type;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } hwph_axi_req_type;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } hwph_axi_rsp_type;

   typedef struct packed {
      logic tx;
      logic rx;
      logic pll;
      logic pa;
   } hwph_rf_type;
endpackage : hwph_pkg

// file: hwph_top.sv
// Host wake handshake, clock request and low-power state sequencer.
//
// What this block does
// - Handshake lines usable only in UART mode.
// - Asserted host wake request wakes the device.
// - Sleep only when request deasserted and conditions met.
// - Both wake lines have software-selected polarity.
// - Device wake output asserted while service needed.
// - Clock request high when either radio needs it.
// - Pad function zero selects handshake pin functions.
// - RF power follows each transmit and receive packet while awake.
// - Sniff sleep runs on LPO, wakes on interval.
// - Shutdown tristates outputs and disables inputs.
// - Leaving shutdown reloads register defaults as at power-up; interrupt status is kept.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module hwph_top (
   input  wire logic                      sys_clk,      // 125 MHz clock
   input  wire logic                      resetn,       // Async reset
   input  wire hwph_pkg::hwph_axi_req_type axiReq,      // AXI4-Lite in
   output hwph_pkg::hwph_axi_rsp_type      axiRsp,      // AXI4-Lite out
   input  wire logic                      uartMode,     // UART transport
   input  wire logic                      hostToDeviceWakeReq, // Wake in
   output logic                           deviceToHostWakeReq, // Wake out
   output logic                           deviceToHostWakeReqOe, // Drive
   output logic                           refClkReq,    // Clock request
   output logic                           refClkReqOe,  // Drive enable
   input  wire logic                      coreSvcReq,   // Core needs host
   input  wire logic                      btClkNeed,    // Radio clock need
   input  wire logic                      wlanClkNeed,  // WLAN clock need
   input  wire logic                      pktTxActive,  // Tx packet window
   input  wire logic                      pktRxActive,  // Rx packet window
   input  wire logic                      lpoClkIn,     // Low-power osc
   output hwph_pkg::hwph_rf_type           rfPower,      // RF power enables
   output logic                           lpoRun,       // Running on LPO
   output logic                           coreAwake,    // Core clocked
   output logic                           inputsDisabled, // Shutdown mask
   output logic                           irq           // Interrupt level
);
   import hwph_pkg::*;

   hwph_state_type        state_q, state_d;
   hwph_ctrl_type         ctrl_q;
   logic [PADFN_W-1:0]    padFn_q;
   logic [IVAL_W-1:0]     interval_q, sleepCnt_q;
   logic [IRQ_W-1:0]      irqStat_q, irqEn_q, irqSet, irqClr;
   logic                  devS1_q, devS2_q, lpoS1_q, lpoS2_q, lpoS3_q;
   logic                  awHeld_q, wHeld_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0]     awAddr_q;
   logic [DATA_W-1:0]     wData_q, rData_q, rdMux;
   logic [3:0]            wStrb_q;
   logic [1:0]            bResp_q, rResp_q;
   logic                  wrFire, rdFire, wrHit, rdHit, softRst;
   logic                  hsActive, devAsserted, needHost, lpoEdge;
   logic                  timerDone, shut, txIn, rxIn;

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
         input logic [DATA_W-1:0] n, input logic [3:0] s);
      logic [DATA_W-1:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // Bus slave: address and data are taken independently, then written.
   assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
   assign rdFire = axiReq.arvalid && !rvalid_q;
   assign wrHit  = awAddr_q == OFS_CTRL || awAddr_q == OFS_PADFN ||
                   awAddr_q == OFS_INTERVAL || awAddr_q == OFS_IRQ_CLR ||
                   awAddr_q == OFS_IRQ_EN;
   assign softRst = state_q == ST_PWRUP;

   always_comb begin
      axiRsp         = '0;
      axiRsp.awready = !awHeld_q && !bvalid_q;
      axiRsp.wready  = !wHeld_q && !bvalid_q;
      axiRsp.bvalid  = bvalid_q;
      axiRsp.bresp   = bResp_q;
      axiRsp.arready = !rvalid_q;
      axiRsp.rvalid  = rvalid_q;
      axiRsp.rdata   = rData_q;
      axiRsp.rresp   = rResp_q;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= '0;
         wData_q  <= '0;
         wStrb_q  <= '0;
         bvalid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
      end else begin
         if (axiReq.awvalid && axiRsp.awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= axiReq.awaddr;
         end
         if (axiReq.wvalid && axiRsp.wready) begin
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata;
            wStrb_q <= axiReq.wstrb;
         end
         if (wrFire) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bResp_q  <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && axiReq.bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rdMux = '0;
      rdHit = 1'b1;
      case (axiReq.araddr)
         OFS_CTRL:     rdMux[CTRL_W-1:0] = ctrl_q;
         OFS_PADFN:    rdMux[PADFN_W-1:0] = padFn_q;
         OFS_INTERVAL: rdMux[IVAL_W-1:0] = interval_q;
         OFS_STATUS:   rdMux[STAT_W-1:0] = {hsActive, needHost,
                                            devAsserted, state_q};
         OFS_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_q;
         OFS_IRQ_CLR:  rdMux = '0;
         OFS_IRQ_EN:   rdMux[IRQ_W-1:0] = irqEn_q;
         default:      rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rData_q  <= '0;
         rResp_q  <= RESP_OKAY;
      end else if (rdFire) begin
         rvalid_q <= 1'b1;
         rData_q  <= rdMux;
         rResp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && axiReq.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Configuration registers; a power-up from shutdown reloads defaults.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q     <= CTRL_RST;
         padFn_q    <= PADFN_RST;
         interval_q <= IVAL_RST;
         irqEn_q    <= IRQ_RST;
      end else if (softRst) begin
         ctrl_q     <= CTRL_RST;
         padFn_q    <= PADFN_RST;
         interval_q <= IVAL_RST;
         irqEn_q    <= IRQ_RST;
      end else if (wrFire) begin
         case (awAddr_q)
            OFS_CTRL: ctrl_q <= hwph_ctrl_type'(CTRL_W'(merge(
                                DATA_W'(ctrl_q), wData_q, wStrb_q)));
            OFS_PADFN: padFn_q <= PADFN_W'(merge(DATA_W'(padFn_q),
                                wData_q, wStrb_q));
            OFS_INTERVAL: interval_q <= IVAL_W'(merge(DATA_W'(interval_q),
                                wData_q, wStrb_q));
            OFS_IRQ_EN: irqEn_q <= IRQ_W'(merge(DATA_W'(irqEn_q),
                                wData_q, wStrb_q));
            default: ;
         endcase
      end
   end

   // Synchronisers for the host wake input and the LPO clock.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         devS1_q <= 1'b0;
         devS2_q <= 1'b0;
         lpoS1_q <= 1'b0;
         lpoS2_q <= 1'b0;
         lpoS3_q <= 1'b0;
      end else begin
         devS1_q <= hostToDeviceWakeReq;
         devS2_q <= devS1_q;
         lpoS1_q <= lpoClkIn;
         lpoS2_q <= lpoS1_q;
         lpoS3_q <= lpoS2_q;
      end
   end

   assign shut     = state_q == ST_SHUT;
   assign hsActive = uartMode && ctrl_q.hsEn &&
                     padFn_q == PADFN_HS;
   assign devAsserted = hsActive &&
                        (ctrl_q.devPol ? devS2_q : !devS2_q);
   assign needHost = ctrl_q.svcReq || (coreSvcReq && !shut);
   assign lpoEdge  = lpoS2_q && !lpoS3_q;
   assign txIn     = pktTxActive && !shut;
   assign rxIn     = pktRxActive && !shut;
   assign timerDone = state_q == ST_SLEEP && lpoEdge &&
                      interval_q != IVAL_RST &&
                      sleepCnt_q == interval_q - 16'h0001;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_AWAKE: begin
            if (ctrl_q.shutdown) begin
               state_d = ST_SHUT;
            end else if (!devAsserted && ctrl_q.sleepOk && !needHost &&
                         !txIn && !rxIn) begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (devAsserted || needHost || timerDone) begin
               state_d = ST_AWAKE;
            end
         end
         ST_SHUT: begin
            if (devAsserted) begin
               state_d = ST_PWRUP;
            end
         end
         ST_PWRUP: state_d = ST_AWAKE;
         default:  state_d = ST_AWAKE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_AWAKE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sleepCnt_q <= '0;
      end else if (state_q != ST_SLEEP || timerDone) begin
         sleepCnt_q <= '0;
      end else if (lpoEdge) begin
         sleepCnt_q <= sleepCnt_q + 16'h0001;
      end
   end

   // Pin and power outputs; drive enables drop while shut down.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         deviceToHostWakeReq <= 1'b0;
         refClkReq      <= 1'b0;
         rfPower        <= '0;
         lpoRun         <= 1'b0;
         coreAwake      <= 1'b1;
         inputsDisabled <= 1'b0;
      end else begin
         deviceToHostWakeReq <= needHost ~^ ctrl_q.hostPol;
         refClkReq      <= (btClkNeed || wlanClkNeed) && !shut;
         rfPower.tx     <= txIn && state_d == ST_AWAKE;
         rfPower.pa     <= txIn && state_d == ST_AWAKE;
         rfPower.rx     <= rxIn && state_d == ST_AWAKE;
         rfPower.pll    <= (txIn || rxIn) && state_d == ST_AWAKE;
         lpoRun         <= state_d == ST_SLEEP;
         coreAwake      <= state_d == ST_AWAKE;
         inputsDisabled <= state_d == ST_SHUT;
      end
   end

   assign deviceToHostWakeReqOe = hsActive && !shut;
   assign refClkReqOe = padFn_q == PADFN_HS && !shut;

   // Sticky events; a set in the clearing cycle survives.
   always_comb begin
      irqSet = '0;
      irqSet[IRQ_HOST_WAKE]  = state_q == ST_SLEEP && devAsserted;
      irqSet[IRQ_TIMER_WAKE] = timerDone;
      irqSet[IRQ_SLEEP]      = state_q == ST_AWAKE && state_d == ST_SLEEP;
      irqSet[IRQ_POWER_UP]   = softRst;
      irqClr = (wrFire && awAddr_q == OFS_IRQ_CLR) ?
               IRQ_W'(wData_q & {24'h0, {8{wStrb_q[0]}}}) : IRQ_RST;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irqStat_q <= IRQ_RST;
      end else begin
         irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
      end
   end

   assign irq = |(irqStat_q & irqEn_q);

   AST_SYNC: assert property (@(posedge sys_clk) disable iff (!resetn)
      1'b1 ##2 1'b1 |-> devS2_q == $past(hostToDeviceWakeReq, 2))
      else $error("Wake input not delayed by two flops.");
   AST_UART_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
      !uartMode |-> !deviceToHostWakeReqOe)
      else $error("Wake output driven outside UART mode.");
   AST_HOST_WAKES: assert property (@(posedge sys_clk) disable iff (!resetn)
      state_q == ST_SLEEP && devAsserted |=> state_q == ST_AWAKE)
      else $error("Asserted host request did not wake device.");
   AST_SLEEP_ENTRY: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      state_q == ST_SLEEP && $past(state_q) == ST_AWAKE |->
      $past(ctrl_q.sleepOk) && !$past(devAsserted))
      else $error("Sleep entered without its conditions.");
   AST_DEV_POL: assert property (@(posedge sys_clk) disable iff (!resetn)
      hsActive && !ctrl_q.devPol && !devS2_q && state_q == ST_SLEEP
      |=> state_q == ST_AWAKE)
      else $error("Low-active wake request ignored.");
   AST_HOST_REQ: assert property (@(posedge sys_clk) disable iff (!resetn)
      needHost && $stable(ctrl_q) ##1 $stable(ctrl_q) |->
      deviceToHostWakeReq == ctrl_q.hostPol)
      else $error("Device wake output not asserted.");
   AST_CLK_REQ: assert property (@(posedge sys_clk) disable iff (!resetn)
      (btClkNeed || wlanClkNeed) && !shut |=> refClkReq)
      else $error("Clock request not raised.");
   AST_PADFN: assert property (@(posedge sys_clk) disable iff (!resetn)
      padFn_q != PADFN_HS |-> !deviceToHostWakeReqOe && !refClkReqOe)
      else $error("Pin driven with other pad function.");
   AST_RF_PKT: assert property (@(posedge sys_clk) disable iff (!resetn)
      pktTxActive && state_q == ST_AWAKE && !ctrl_q.shutdown
      |=> rfPower.tx && rfPower.pll)
      else $error("RF not powered for transmit packet.");
   AST_TIMER_WAKE: assert property (@(posedge sys_clk) disable iff (!resetn)
      timerDone |=> state_q == ST_AWAKE && !lpoRun && coreAwake)
      else $error("Interval expiry did not wake device.");
   AST_SHUT_TRI: assert property (@(posedge sys_clk) disable iff (!resetn)
      shut |-> !deviceToHostWakeReqOe && !refClkReqOe ##1
      (inputsDisabled || state_q != ST_SHUT))
      else $error("Output driven during shutdown.");
   AST_PWRUP: assert property (@(posedge sys_clk) disable iff (!resetn)
      softRst |=> ctrl_q == CTRL_RST && padFn_q == PADFN_RST &&
      state_q == ST_AWAKE)
      else $error("Power-up kept old state.");

   COV_SLEEP: cover property (@(posedge sys_clk) disable iff (!resetn)
      state_q == ST_AWAKE ##1 state_q == ST_SLEEP);
   COV_TIMER: cover property (@(posedge sys_clk) disable iff (!resetn)
      timerDone);
   COV_SHUT_UP: cover property (@(posedge sys_clk) disable iff (!resetn)
      shut ##1 softRst);
endmodule : hwph_top

// file: hwph_host_model.sv
// Host processor model that faces the wake handshake pins of the block.
`timescale 1ns/1ps
module hwph_host_model (
   input  wire logic sys_clk,     // System clock
   input  wire logic resetn,      // Async reset, active low
   input  wire logic wakeWant,    // Host wants the device awake
   input  wire logic slow,        // Answer four cycles late
   input  wire logic devPolHigh,  // Assert level of the host request
   input  wire logic hostPolHigh, // Assert level of the device request
   input  wire logic devWake,     // Device request pin
   input  wire logic devWakeOe,   // Device drives its request pin
   output logic      hostWakePin, // Host request pin
   output logic      hostAwake    // Host kept out of sleep
);
   logic [3:0] dly_q;
   logic       seen_q;
   logic       lineLvl;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dly_q  <= 4'h0;
         seen_q <= 1'b0;
      end else begin
         dly_q  <= {dly_q[2:0], wakeWant};
         if (devWakeOe) begin
            seen_q <= devWake;
         end
      end
   end

   // A released pin has no pull; the host sees the inverse of its last level.
   assign lineLvl     = devWakeOe ? devWake : !seen_q;
   assign hostWakePin = (slow ? dly_q[3] : wakeWant) ~^ devPolHigh;
   assign hostAwake   = wakeWant | (lineLvl == hostPolHigh);
endmodule : hwph_host_model

// file: hwph_top_bench.sv
// Self-checking bench for the wake handshake and low-power sequencer.
`timescale 1ns/1ps
module hwph_top_bench;
   import hwph_pkg::*;
   logic             sys_clk = 1'b0;
   logic             resetn = 1'b0;
   hwph_axi_req_type req = '0;
   hwph_axi_rsp_type rsp;
   hwph_rf_type      rfPower;
   logic uartMode = 1'b1, coreSvcReq = 1'b0, btClkNeed = 1'b0;
   logic wlanClkNeed = 1'b0, pktTxActive = 1'b0, pktRxActive = 1'b0;
   logic lpoClkIn = 1'b0, wakeWant = 1'b0, slow = 1'b0;
   logic devPolHigh = 1'b1, hostPolHigh = 1'b1;
   logic [2:0] lpoCnt = 3'h0;
   logic hostWakePin, deviceToHostWakeReq, deviceToHostWakeReqOe;
   logic refClkReq, refClkReqOe, lpoRun, coreAwake, inputsDisabled;
   logic irq, hostAwake;
   int   fail_count = 0;
   int   total_checks = 0;

   always #4 sys_clk = !sys_clk;

   always @(posedge sys_clk) begin
      lpoCnt <= lpoCnt + 3'h1;
      if (lpoCnt == 3'h7) lpoClkIn <= !lpoClkIn;
   end

   hwph_top i_hwph_top (
      .sys_clk(sys_clk), .resetn(resetn), .axiReq(req), .axiRsp(rsp),
      .uartMode(uartMode), .hostToDeviceWakeReq(hostWakePin),
      .deviceToHostWakeReq(deviceToHostWakeReq),
      .deviceToHostWakeReqOe(deviceToHostWakeReqOe),
      .refClkReq(refClkReq), .refClkReqOe(refClkReqOe),
      .coreSvcReq(coreSvcReq), .btClkNeed(btClkNeed),
      .wlanClkNeed(wlanClkNeed), .pktTxActive(pktTxActive),
      .pktRxActive(pktRxActive), .lpoClkIn(lpoClkIn), .rfPower(rfPower),
      .lpoRun(lpoRun), .coreAwake(coreAwake),
      .inputsDisabled(inputsDisabled), .irq(irq)
   );

   hwph_host_model i_hwph_host_model (
      .sys_clk(sys_clk), .resetn(resetn), .wakeWant(wakeWant),
      .slow(slow), .devPolHigh(devPolHigh), .hostPolHigh(hostPolHigh),
      .devWake(deviceToHostWakeReq), .devWakeOe(deviceToHostWakeReqOe),
      .hostWakePin(hostWakePin), .hostAwake(hostAwake)
   );

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic wrChk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = RESP_OKAY);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      check({30'h0, rsp.bresp}, {30'h0, er});
      req.bready <= 1'b0;
      @(posedge sys_clk);
   endtask : wrChk

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er = RESP_OKAY,
                        input logic [31:0] m = 32'hffffffff);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      check(rsp.rdata & m, exp);
      check({30'h0, rsp.rresp}, {30'h0, er});
      req.rready <= 1'b0;
      @(posedge sys_clk);
   endtask : rdChk

   initial begin
      cyc(5000);
      fail_count++;
      results();
   end

   initial begin
      cyc(12);
      resetn <= 1'b1;
      cyc(1);
      rdChk(OFS_CTRL, 32'h6);
      rdChk(OFS_PADFN, 32'h0);
      rdChk(OFS_INTERVAL, 32'h0);
      rdChk(OFS_IRQ_EN, 32'h0);
      rdChk(OFS_STATUS, 32'h0);
      rdChk(8'h40, 32'h0, RESP_SLVERR);
      wrChk(OFS_STATUS, 32'h1, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         {btClkNeed, wlanClkNeed} <= i[1:0];
         cyc(3);
         check(refClkReq, |i[1:0]);
      end
      pktTxActive <= 1'b1;
      cyc(3);
      check(32'(rfPower), 32'hb);
      pktTxActive <= 1'b0;
      pktRxActive <= 1'b1;
      cyc(3);
      check(32'(rfPower), 32'h6);
      pktRxActive <= 1'b0;
      cyc(3);
      check(32'(rfPower), 32'h0);
      wrChk(OFS_CTRL, 32'h07);
      coreSvcReq <= 1'b1;
      cyc(3);
      check(deviceToHostWakeReq, 1'b1);
      check(hostAwake, 1'b1);
      check(deviceToHostWakeReqOe, 1'b1);
      hostPolHigh <= 1'b0;
      wrChk(OFS_CTRL, 32'h03);
      cyc(2);
      check(deviceToHostWakeReq, 1'b0);
      coreSvcReq <= 1'b0;
      cyc(3);
      check(deviceToHostWakeReq, 1'b1);
      check(hostAwake, 1'b0);
      wrChk(OFS_CTRL, 32'h13);
      cyc(2);
      check(deviceToHostWakeReq, 1'b0);
      hostPolHigh <= 1'b1;
      wrChk(OFS_PADFN, 32'h1);
      cyc(2);
      check(deviceToHostWakeReqOe, 1'b0);
      wrChk(OFS_PADFN, 32'h0);
      cyc(2);
      check(deviceToHostWakeReqOe, 1'b1);
      wrChk(OFS_CTRL, 32'h0f);
      cyc(3);
      check(lpoRun, 1'b1);
      check(coreAwake, 1'b0);
      rdChk(OFS_STATUS, 32'h1, RESP_OKAY, 32'h3);
      wakeWant <= 1'b1;
      cyc(3);
      check(coreAwake, 1'b0);
      cyc(1);
      check(coreAwake, 1'b1);
      cyc(12);
      check(coreAwake, 1'b1);
      wakeWant <= 1'b0;
      cyc(8);
      check(lpoRun, 1'b1);
      slow <= 1'b1;
      devPolHigh <= 1'b0;
      wrChk(OFS_CTRL, 32'h0d);
      cyc(6);
      check(lpoRun, 1'b1);
      uartMode <= 1'b0;
      wakeWant <= 1'b1;
      cyc(14);
      check(lpoRun, 1'b1);
      uartMode <= 1'b1;
      cyc(14);
      check(coreAwake, 1'b1);
      wakeWant <= 1'b0;
      slow <= 1'b0;
      devPolHigh <= 1'b1;
      wrChk(OFS_CTRL, 32'h07);
      rdChk(OFS_IRQ_STAT, 32'h5);
      check(irq, 1'b0);
      wrChk(OFS_IRQ_EN, 32'h4);
      cyc(2);
      check(irq, 1'b1);
      wrChk(OFS_IRQ_CLR, 32'h4);
      cyc(2);
      check(irq, 1'b0);
      rdChk(OFS_IRQ_STAT, 32'h1);
      rdChk(OFS_IRQ_CLR, 32'h0);
      wrChk(OFS_IRQ_CLR, 32'h1);
      wrChk(OFS_IRQ_STAT, 32'h1, RESP_SLVERR);
      wrChk(OFS_INTERVAL, 32'h3);
      wrChk(OFS_CTRL, 32'h0f);
      cyc(20);
      rdChk(OFS_IRQ_STAT, 32'h0, RESP_OKAY, 32'h2);
      cyc(60);
      rdChk(OFS_IRQ_STAT, 32'h2, RESP_OKAY, 32'h2);
      wrChk(OFS_CTRL, 32'h07);
      cyc(60);
      btClkNeed <= 1'b1;
      wrChk(OFS_CTRL, 32'h27);
      cyc(3);
      check(inputsDisabled, 1'b1);
      check(refClkReqOe, 1'b0);
      check(deviceToHostWakeReqOe, 1'b0);
      check(refClkReq, 1'b0);
      wakeWant <= 1'b1;
      cyc(10);
      wakeWant <= 1'b0;
      check(inputsDisabled, 1'b0);
      rdChk(OFS_CTRL, 32'h6);
      rdChk(OFS_INTERVAL, 32'h0);
      rdChk(OFS_IRQ_STAT, 32'h8, RESP_OKAY, 32'h8);
      check(refClkReq, 1'b1);
      results();
   end
endmodule : hwph_top_bench
